// *** hw/gpp_pkg.sv ***
package gpp_pkg;
    // ******************************************************
    // register map, byte addresses of aligned 32-bit words
    // ******************************************************
    localparam logic [11:0] GPP_OFS_PAD_SAMPLE = 12'h000;
    localparam logic [11:0] GPP_OFS_DIRECTION = 12'h004;
    localparam logic [11:0] GPP_OFS_OUT_LATCH = 12'h008;
    localparam logic [11:0] GPP_OFS_MCU_CTRL = 12'h00C;
    // field positions and reset values
    localparam int GPP_PUD_BIT = 0;
    localparam logic GPP_PUD_RESET = 1'h0;
    localparam int GPP_PIN_COUNT = 8;
    localparam int GPP_ADDR_WIDTH = 12;
    // synchroniser readback delay, in system clock periods
    localparam int GPP_READBACK_CYCLES = 1;
    // apb slave states, one-hot
    typedef enum logic [1:0] {
        GPP_ST_IDLE = 2'b01,
        GPP_ST_ACCESS = 2'b10
    } gpp_apb_state_t;
endpackage

// *** hw/gpp_port.sv ***
`timescale 1ns/10ps
// How it works
// - dir_bit one drives pin, zero makes input
// - input with latch one and no pud: pull-up
// - latch zero or output: pull-up off
// - reset tri-states pads at once, clockless
// - output pin follows out_latch_bit level
// - writing one to sample bit toggles latch
// - global_pullup_off kills every pull-up
// - pad read via latch plus flop always
// - latch open while clock high, then flop
// - pad edge seen after half to 1.5 periods
// - written value reaches latch at write edge
// - written value readable one clock later
// - four registers: three one bit per pin, one control bit
// - sample read-only, others read and write
module gpp_port
    import gpp_pkg::*;
#(
    parameter int PINS = GPP_PIN_COUNT
) (
    input wire logic sys_clk,
    input wire logic rst,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [GPP_ADDR_WIDTH-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [PINS-1:0] pad_in,
    output logic [PINS-1:0] pad_out,
    output logic [PINS-1:0] pad_oe,
    output logic [PINS-1:0] pad_pullup
);

    // ******************************************************
    // register state
    // ******************************************************
    logic [PINS-1:0] direction_reg;
    logic [PINS-1:0] output_latch_reg;
    logic [PINS-1:0] pad_sample_reg;
    logic global_pullup_off_reg;
    logic [PINS-1:0] direction_next;
    logic [PINS-1:0] output_latch_next;
    logic global_pullup_off_next;
    logic [PINS-1:0] sync_latch;
    gpp_apb_state_t state_reg;
    logic wr_en;
    logic rd_setup;
    logic addr_hit;
    logic [31:0] rd_mux;

    // ******************************************************
    // apb slave: setup, then one access cycle with pready
    // ******************************************************
    // pready is registered so every bus output comes from a flop;
    // the cost is a fixed single wait-free access phase
    assign rd_setup = psel && !penable;
    assign wr_en = psel && penable && pready && pwrite;

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            state_reg <= GPP_ST_IDLE;
        end else begin
            case (state_reg)
                GPP_ST_IDLE: begin
                    if (rd_setup) begin
                        state_reg <= GPP_ST_ACCESS;
                    end
                end
                GPP_ST_ACCESS: begin
                    state_reg <= GPP_ST_IDLE;
                end
                default: begin
                    state_reg <= GPP_ST_IDLE;
                end
            endcase
        end
    end

    // address decode and read mux, unmapped reads zero
    always_comb begin
        addr_hit = 1'b1;
        rd_mux = 32'h0000_0000;
        case (paddr)
            GPP_OFS_PAD_SAMPLE: rd_mux[PINS-1:0] = pad_sample_reg;
            GPP_OFS_DIRECTION: rd_mux[PINS-1:0] = direction_reg;
            GPP_OFS_OUT_LATCH: rd_mux[PINS-1:0] = output_latch_reg;
            GPP_OFS_MCU_CTRL: rd_mux[GPP_PUD_BIT] = global_pullup_off_reg;
            default: addr_hit = 1'b0;
        endcase
    end

    // answer flops, loaded in the setup cycle
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end else begin
            pready <= rd_setup && (state_reg == GPP_ST_IDLE);
            pslverr <= rd_setup && (state_reg == GPP_ST_IDLE) && !addr_hit;
            prdata <= (rd_setup && !pwrite) ? rd_mux : 32'h0000_0000;
        end
    end

    // ******************************************************
    // port registers
    // ******************************************************
    // next values feed both the registers and the pad drivers so a
    // write reaches the pad at the very edge that performs it
    always_comb begin
        direction_next = direction_reg;
        output_latch_next = output_latch_reg;
        global_pullup_off_next = global_pullup_off_reg;
        if (wr_en && addr_hit) begin
            case (paddr)
                GPP_OFS_DIRECTION: direction_next = pwdata[PINS-1:0];
                GPP_OFS_OUT_LATCH: output_latch_next = pwdata[PINS-1:0];
                // sample bits store nothing; a one flips the latch
                GPP_OFS_PAD_SAMPLE: output_latch_next = output_latch_reg ^ pwdata[PINS-1:0];
                GPP_OFS_MCU_CTRL: global_pullup_off_next = pwdata[GPP_PUD_BIT];
                default: direction_next = direction_reg;
            endcase
        end
    end

    always_ff @(posedge sys_clk) begin
        if (rst) begin
            direction_reg <= '0;
            output_latch_reg <= '0;
            global_pullup_off_reg <= GPP_PUD_RESET;
        end else begin
            direction_reg <= direction_next;
            output_latch_reg <= output_latch_next;
            global_pullup_off_reg <= global_pullup_off_next;
        end
    end

    // ******************************************************
    // pad drivers
    // ******************************************************
    // asynchronous reset here only: the pads must float even with no
    // clock, the rest of the block keeps the synchronous reset
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            pad_oe <= '0;
            pad_out <= '0;
            pad_pullup <= '0;
        end else begin
            pad_oe <= direction_next;
            pad_out <= direction_next & output_latch_next;
            // pull-up only on an input whose latch is one, unless disabled
            pad_pullup <= ~direction_next & output_latch_next
                & {PINS{~global_pullup_off_next}};
        end
    end

    // ******************************************************
    // input synchroniser
    // ******************************************************
    // transparent while the clock is high, holds through the low phase
    always_latch begin
        if (sys_clk) begin
            sync_latch = pad_in;
        end
    end

    // only this flop reads the latch
    always_ff @(posedge sys_clk) begin
        if (rst) begin
            pad_sample_reg <= '0;
        end else begin
            pad_sample_reg <= sync_latch;
        end
    end

    // ******************************************************
    // checks
    // ******************************************************
    a_reset_tristate: assert property (@(posedge sys_clk)
        rst |-> (pad_oe == '0) && (pad_pullup == '0))
        else $error("pads not released during reset");

    a_direction_drive: assert property (@(posedge sys_clk) disable iff (rst)
        $past(!rst) |-> (pad_oe == direction_reg))
        else $error("output enable differs from direction");

    a_output_level: assert property (@(posedge sys_clk) disable iff (rst)
        $past(!rst) |-> ((pad_out & direction_reg) == (output_latch_reg & direction_reg)))
        else $error("driven level differs from latch");

    a_pullup_on: assert property (@(posedge sys_clk) disable iff (rst)
        $past(!rst) |-> (pad_pullup == (~direction_reg & output_latch_reg
        & {PINS{~global_pullup_off_reg}})))
        else $error("pull-up state wrong");

    a_pullup_off: assert property (@(posedge sys_clk) disable iff (rst)
        (pad_pullup & (direction_reg | ~output_latch_reg)) == '0)
        else $error("pull-up on for output or zero latch");

    a_global_disable: assert property (@(posedge sys_clk) disable iff (rst)
        global_pullup_off_reg |-> (pad_pullup == '0))
        else $error("pull-up on while globally disabled");

    a_toggle_write: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_PAD_SAMPLE) |=>
        (output_latch_reg == ($past(output_latch_reg) ^ $past(pwdata[PINS-1:0]))))
        else $error("sample write did not toggle latch");

    // the pad moves just after the write edge; one edge on the flop holds it
    a_readback_delay: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_DIRECTION) ##1 1'b1
        |=> (pad_sample_reg == $past(pad_in)))
        else $error("pad level not sampled one clock later");

    a_sample_ro: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_PAD_SAMPLE) |=> $stable(direction_reg))
        else $error("sample write disturbed direction");

    // checked on the first edge out of reset, so no unset state is seen
    a_reset_zero: assert property (@(posedge sys_clk)
        $past(rst) && !rst |-> (direction_reg == '0) && (output_latch_reg == '0))
        else $error("registers not zero after reset");

    a_apb_answer: assert property (@(posedge sys_clk) disable iff (rst)
        (psel && !penable && state_reg == GPP_ST_IDLE) |=> pready ##1 !pready)
        else $error("access phase not answered in one cycle");

    c_toggle: cover property (@(posedge sys_clk) disable iff (rst)
        wr_en && paddr == GPP_OFS_PAD_SAMPLE && pwdata[PINS-1:0] != '0);
    c_pullup_input: cover property (@(posedge sys_clk) disable iff (rst)
        pad_pullup != '0);
    c_output_high: cover property (@(posedge sys_clk) disable iff (rst)
        (pad_oe & pad_out) != '0);
    c_unmapped: cover property (@(posedge sys_clk) disable iff (rst)
        pready && pslverr);
    c_readback: cover property (@(posedge sys_clk) disable iff (rst)
        pready && !pslverr && paddr == GPP_OFS_PAD_SAMPLE);

    // ******************************************************
    // further checks: bus, register and synchroniser
    // ******************************************************
    // these watch the register file and the bus answer flops; they
    // guard the places where a later edit would most easily slip,
    // such as a decode arm that writes the wrong register or a read
    // mux that leaks a value outside the access cycle

    // the flop takes whatever the latch held through the low phase
    // so nothing else may sit between the latch and the sample bit
    a_sync_capture: assert property (@(posedge sys_clk) disable iff (rst)
        1'b1 |=> (pad_sample_reg == $past(sync_latch)))
        else $error("sample flop did not take latch value");

    // a pad level held over a whole period lands on the next edge;
    // this is the 1.5-period end of the delay window
    a_pad_delay: assert property (@(posedge sys_clk) disable iff (rst)
        (pad_in == $past(pad_in)) |=> (pad_sample_reg == $past(pad_in)))
        else $error("steady pad level not sampled");

    // read data is only driven in the access cycle, zero otherwise,
    // so a master that samples late cannot pick up stale data
    a_prdata_idle: assert property (@(posedge sys_clk) disable iff (rst)
        !pready |-> (prdata == '0))
        else $error("read data outside access cycle");

    // an error answer never stands without its ready
    a_err_ready: assert property (@(posedge sys_clk) disable iff (rst)
        pslverr |-> pready)
        else $error("error without ready");

    // ready is a one-cycle pulse, never two in a row
    a_ready_single: assert property (@(posedge sys_clk) disable iff (rst)
        pready |=> !pready)
        else $error("ready held longer than one cycle");

    // a direction write stores exactly the pin bits of the word
    // and nothing from the upper half
    a_write_dir: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_DIRECTION)
        |=> (direction_reg == $past(pwdata[PINS-1:0])))
        else $error("direction write lost");

    // a latch write stores the pin bits, it does not toggle them
    a_write_latch: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_OUT_LATCH)
        |=> (output_latch_reg == $past(pwdata[PINS-1:0])))
        else $error("latch write lost");

    // the global pull-up switch takes its single bit of the word
    a_write_pud: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_MCU_CTRL)
        |=> (global_pullup_off_reg == $past(pwdata[GPP_PUD_BIT])))
        else $error("pull-up disable write lost");

    // a write to a hole in the map must leave every register alone
    a_unmapped_ignored: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && !addr_hit) |=> $stable(direction_reg) && $stable(output_latch_reg)
        && $stable(global_pullup_off_reg))
        else $error("unmapped write changed a register");

    // a latch write shows on the driven pads at the same edge
    a_latch_to_pad: assert property (@(posedge sys_clk) disable iff (rst)
        (wr_en && paddr == GPP_OFS_OUT_LATCH)
        |=> (pad_out == (direction_reg & output_latch_reg)))
        else $error("latch write did not reach the pad");

    // with no write on the bus the latch keeps its value
    a_latch_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_en |=> $stable(output_latch_reg))
        else $error("latch changed without a write");

    // with no write on the bus the direction keeps its value
    a_dir_hold: assert property (@(posedge sys_clk) disable iff (rst)
        !wr_en |=> $stable(direction_reg))
        else $error("direction changed without a write");

    // a direction read returns the register as it stood at setup
    a_dir_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_setup && !pwrite && paddr == GPP_OFS_DIRECTION && state_reg == GPP_ST_IDLE)
        |=> (prdata[PINS-1:0] == $past(direction_reg)))
        else $error("direction read wrong");

    // a sample read returns the flop, whatever the direction
    a_sample_read: assert property (@(posedge sys_clk) disable iff (rst)
        (rd_setup && !pwrite && paddr == GPP_OFS_PAD_SAMPLE && state_reg == GPP_ST_IDLE)
        |=> (prdata[PINS-1:0] == $past(pad_sample_reg)))
        else $error("sample read wrong");

endmodule

// *** verification/gpp_pad_model.sv ***
`timescale 1ns/10ps
// ************************************************
// pads and the circuitry outside them
// ************************************************
module gpp_pad_model (
    input wire logic sys_clk,
    input wire logic [7:0] pad_out,
    input wire logic [7:0] pad_oe,
    input wire logic [7:0] pad_pullup,
    input wire logic [7:0] ext_en,
    input wire logic [7:0] ext_val,
    output logic [7:0] pad_in
);
    logic [7:0] last_lvl = 8'h00;
    // a bare pad is not trusted to hold: it shows the inverse of its last level
    always @(posedge sys_clk) begin
        last_lvl <= pad_in;
    end
    // device drive wins, then the outside driver, then the pull-up
    assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_en & ext_val)
        | (~pad_oe & ~ext_en & pad_pullup) | (~pad_oe & ~ext_en & ~pad_pullup & ~last_lvl);
endmodule

// *** verification/tb_general_digital_io_port_pin.sv ***
`timescale 1ns/10ps
// ************************************************
// bench for the port pin block
// ************************************************
module tb_general_digital_io_port_pin;
    import gpp_pkg::*;
    logic sys_clk = 1'b0;
    logic rst = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata, rd;
    logic pready, pslverr, err;
    logic [7:0] pad_in, pad_out, pad_oe, pad_pullup;
    logic [7:0] ext_en = 8'hF0;
    logic [7:0] ext_val = 8'h50;
    int n_fail = 0;
    int checks_done = 0;
    int cyc = 0;

    gpp_port #(.PINS(8)) dut (.sys_clk(sys_clk), .rst(rst), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pad_in(pad_in), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup));
    gpp_pad_model u_pads (.sys_clk(sys_clk), .pad_out(pad_out), .pad_oe(pad_oe),
        .pad_pullup(pad_pullup), .ext_en(ext_en), .ext_val(ext_val), .pad_in(pad_in));

    initial begin
        forever #4 sys_clk = ~sys_clk;
    end

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask

    // one transfer plus one idle cycle, so a readback never follows a write too closely
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge sys_clk);
        penable <= 1'b1;
        do begin
            @(posedge sys_clk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge sys_clk);
    endtask

    task automatic complete_run();
        $display("checks %0d mismatches %0d", checks_done, n_fail);
        if (n_fail == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    task automatic t_reset();
        apb(1'b0, GPP_OFS_DIRECTION, 32'h0);
        check("dir reset", rd, 32'h0);
        apb(1'b0, GPP_OFS_OUT_LATCH, 32'h0);
        check("latch reset", rd, 32'h0);
        apb(1'b0, GPP_OFS_MCU_CTRL, 32'h0);
        check("mcu reset", rd, 32'h0);
        check("oe reset", {24'h0, pad_oe | pad_pullup}, 32'h0);
        $display("test reset done");
    endtask

    // pins 0,1 go 00 -> 01 -> 11, pins 2,3 go 00 -> 10
    task automatic t_config();
        apb(1'b1, GPP_OFS_OUT_LATCH, 32'h03);
        check("pullup in", {24'h0, pad_pullup}, 32'h03);
        check("oe input", {24'h0, pad_oe}, 32'h0);
        apb(1'b1, GPP_OFS_DIRECTION, 32'h0F);
        check("oe out", {24'h0, pad_oe}, 32'h0F);
        check("drive", {24'h0, pad_out}, 32'h03);
        check("pullup out", {24'h0, pad_pullup}, 32'h0);
        apb(1'b0, GPP_OFS_PAD_SAMPLE, 32'h0);
        check("readback", rd, 32'h53);
        $display("test config done");
    endtask

    task automatic t_toggle();
        apb(1'b1, GPP_OFS_PAD_SAMPLE, 32'h81);
        apb(1'b0, GPP_OFS_OUT_LATCH, 32'h0);
        check("toggle", rd, 32'h82);
        check("pullup p7", {24'h0, pad_pullup}, 32'h80);
        check("drive", {24'h0, pad_out}, 32'h02);
        apb(1'b0, GPP_OFS_DIRECTION, 32'h0);
        check("dir kept", rd, 32'h0F);
        $display("test toggle done");
    endtask

    task automatic t_pud();
        apb(1'b1, GPP_OFS_MCU_CTRL, 32'h1);
        check("pud", {24'h0, pad_pullup}, 32'h0);
        apb(1'b0, GPP_OFS_MCU_CTRL, 32'h0);
        check("mcu rd", rd, 32'h1);
        apb(1'b0, 12'h010, 32'h0);
        check("unmapped err", {31'h0, err}, 32'h1);
        check("unmapped rd", rd, 32'h0);
        $display("test pud done");
    endtask

    // the pad changes just after an edge; the flop captures it one edge later, the read's setup edge is the one after
    task automatic t_edge();
        ext_val <= 8'hA0;
        @(posedge sys_clk);
        apb(1'b0, GPP_OFS_PAD_SAMPLE, 32'h0);
        check("pad edge", rd, 32'hA2);
        $display("test edge done");
    endtask

    task automatic t_async();
        rst <= 1'b1;
        #1;
        check("async oe", {24'h0, pad_oe | pad_out}, 32'h0);
        repeat (2) @(posedge sys_clk);
        rst <= 1'b0;
        apb(1'b0, GPP_OFS_DIRECTION, 32'h0);
        check("dir after rst", rd, 32'h0);
        $display("test async done");
    endtask

    always @(posedge sys_clk) begin
        cyc++;
        if (cyc == 2000) begin
            n_fail++;
            complete_run();
        end
    end

    initial begin
        rst <= 1'b1;
        repeat (12) @(posedge sys_clk);
        rst <= 1'b0;
        t_reset();
        t_config();
        t_toggle();
        t_pud();
        t_edge();
        t_async();
        complete_run();
    end
endmodule
